// ### hdl/reset_combiner_pkg.sv
package reset_combiner_pkg;

   // Register byte addresses on the AXI4-Lite port.
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_INFO = 4'h4;

   // Bit positions of the reset cause status register.
   localparam int BIT_TRAP = 15;
   localparam int BIT_ILLEGAL = 14;
   localparam int BIT_CFG_MISMATCH = 9;
   localparam int BIT_REG_KEEP = 8;
   localparam int BIT_PIN = 7;
   localparam int BIT_SOFT_RESET = 6;
   localparam int BIT_SOFT_WDT_EN = 5;
   localparam int BIT_WDT_TIMEOUT = 4;
   localparam int BIT_SLEEP = 3;
   localparam int BIT_IDLE = 2;
   localparam int BIT_BROWNOUT = 1;
   localparam int BIT_POWER_ON = 0;

   // Value after power-on and the mask of implemented bits.
   localparam logic [15:0] STATUS_RST = 16'h0003;
   localparam logic [15:0] STATUS_IMPL_MASK = 16'hc3ff;

   // Timing in nanoseconds and the derived clock-cycle counts.
   localparam int CLK_PERIOD_NS = 40;
   localparam int T_POR_NS = 10000;
   localparam int T_RST_NS = 20000;
   localparam int T_VREG_NS = 10000;
   localparam int T_POWER_UP_TIMER_NS = 64000000;
   localparam int CNT_W = 21;
   localparam logic [CNT_W-1:0] POR_CYC = CNT_W'((T_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RST_CYC = CNT_W'((T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] VREG_CYC = CNT_W'((T_VREG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] POWER_UP_TIMER_CYC = CNT_W'((T_POWER_UP_TIMER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Oscillator start-up timer: a 10-bit counter of 1024 periods.
   localparam int OST_W = 10;
   localparam logic [OST_W-1:0] OST_LAST = 10'h3ff;

   // AXI response codes.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Reset sequencer states, Gray coded along run, hold, delay.
   typedef enum logic [1:0] {
      ST_RUN = 2'h0,
      ST_HOLD = 2'h1,
      ST_DELAY = 2'h3
   } seq_state_type;

endpackage

// ### hdl/reset_source_combiner.sv
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
// Contract
// - Nine reset sources merge into one function.
// - Any active source drives system reset active.
// - Each reset kind sets its own flag.
// - Power-on clears flags, sets bits one, zero.
// - Software writes flags freely, never causes reset.
// - Bit 15 set by trap conflict reset.
// - Bit 14 set by illegal opcode or uninit.
// - Bits 13 to 10 read zero, ignore writes.
// - Bit 9 set by configuration mismatch reset.
// - Bit 8 keeps regulator active in sleep.
// - Bit 7 set by master clear pin reset.
// - Bit 6 set by reset instruction.
// - Bit 5 enables watchdog; fuse forces it.
// - Bit 4 set by timeout, cleared by power-save.
// - Bit 3 set when entering sleep.
// - Bit 2 set when entering idle.
// - Bit 1 set by brown-out and power-on.
// - Bit 0 set by power-on only.
// - Clock source chosen by reset type when switching.
// - Without switching, clock source from configuration.
// - Release only after power-on and startup delays.
// - Start-up timer counts 1024 oscillator periods.
module reset_source_combiner #(
   parameter logic [reset_combiner_pkg::CNT_W-1:0] POWER_UP_TIMER_CYCLES = reset_combiner_pkg::POWER_UP_TIMER_CYC
) (
   // Clock, reset and clock enable.
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // AXI4-Lite write channels.
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels.
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Reset sources from pins.
   input wire logic master_clear_pin,
   input wire logic brownout_reset,
   // Reset and power events from same-clock logic.
   input wire logic watchdog_timeout,
   input wire logic reset_instruction,
   input wire logic trap_conflict,
   input wire logic illegal_opcode,
   input wire logic uninit_workreg_reset,
   input wire logic config_word_mismatch,
   input wire logic sleep_entry,
   input wire logic idle_entry,
   // Configuration inputs.
   input wire logic fuse_watchdog_enable,
   input wire logic clock_switch_enable,
   input wire logic regulator_enabled,
   input wire logic [2:0] new_osc_config_field,
   input wire logic [2:0] current_osc_field,
   // System side outputs.
   output logic system_reset_line,
   output logic regulator_sleep_keep,
   output logic watchdog_run,
   output logic [2:0] clock_source_sel,
   output logic osc_clock_released
);

   typedef struct packed {
      logic master_clear_pin_meta;
      logic master_clear_pin_sync;
      logic bo_meta;
      logic bo_sync;
      reset_combiner_pkg::seq_state_type state;
      logic [reset_combiner_pkg::CNT_W-1:0] cnt;
      logic por_pend;
      logic por_bor;
      logic [2:0] clk_sel;
      logic [reset_combiner_pkg::OST_W-1:0] ost_cnt;
      logic ost_done;
      logic [15:0] status;
      logic aw_got;
      logic [3:0] aw_addr;
      logic w_got;
      logic [15:0] w_data;
      logic [1:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [15:0] rdata;
   } regs_type;

   regs_type q;
   regs_type d;
   logic src_any;
   logic [15:0] set_vec;
   logic [15:0] info_word;
   logic [reset_combiner_pkg::CNT_W-1:0] delay_load;
   logic [reset_combiner_pkg::CNT_W-1:0] startup_cyc;

   // Eight sources form one combined reset request; power-on enters through aresetn.
   assign src_any = q.master_clear_pin_sync | q.bo_sync | watchdog_timeout | reset_instruction | trap_conflict
                    | illegal_opcode | uninit_workreg_reset | config_word_mismatch;

   // Release delay depends on the kind of reset being served.
   assign startup_cyc = regulator_enabled ? reset_combiner_pkg::VREG_CYC : POWER_UP_TIMER_CYCLES;
   assign delay_load = reset_combiner_pkg::RST_CYC
                       + (q.por_bor ? startup_cyc : '0)
                       + (q.por_pend ? reset_combiner_pkg::POR_CYC : '0);

   assign info_word = {8'h00, q.clk_sel, q.ost_done, watchdog_run, q.state, q.por_bor};

   // Handshake readies are gated so a frozen clock enable loses nothing.
   assign awready = clk_en & ~q.aw_got & ~q.bvalid;
   assign wready = clk_en & ~q.w_got & ~q.bvalid;
   assign arready = clk_en & ~q.rvalid;
   assign bvalid = q.bvalid;
   assign bresp = q.bresp;
   assign rvalid = q.rvalid;
   assign rresp = q.rresp;
   assign rdata = {16'h0000, q.rdata};

   assign system_reset_line = ~aresetn | (q.state != reset_combiner_pkg::ST_RUN);
   assign regulator_sleep_keep = q.status[reset_combiner_pkg::BIT_REG_KEEP];
   assign watchdog_run = fuse_watchdog_enable | q.status[reset_combiner_pkg::BIT_SOFT_WDT_EN];
   assign clock_source_sel = q.clk_sel;
   assign osc_clock_released = q.ost_done;

   always_comb begin
      d = q;
      // Pins pass two flip-flops before use.
      d.master_clear_pin_meta = master_clear_pin;
      d.master_clear_pin_sync = q.master_clear_pin_meta;
      d.bo_meta = brownout_reset;
      d.bo_sync = q.bo_meta;

      // Cause flags set by hardware events.
      set_vec = 16'h0000;
      set_vec[reset_combiner_pkg::BIT_TRAP] = trap_conflict;
      set_vec[reset_combiner_pkg::BIT_ILLEGAL] = illegal_opcode | uninit_workreg_reset;
      set_vec[reset_combiner_pkg::BIT_CFG_MISMATCH] = config_word_mismatch;
      set_vec[reset_combiner_pkg::BIT_PIN] = q.master_clear_pin_sync;
      set_vec[reset_combiner_pkg::BIT_SOFT_RESET] = reset_instruction;
      set_vec[reset_combiner_pkg::BIT_WDT_TIMEOUT] = watchdog_timeout;
      set_vec[reset_combiner_pkg::BIT_SLEEP] = sleep_entry;
      set_vec[reset_combiner_pkg::BIT_IDLE] = idle_entry;
      set_vec[reset_combiner_pkg::BIT_BROWNOUT] = q.bo_sync;

      // Write address and data are taken in either order.
      if (awvalid && awready) begin
         d.aw_got = 1'b1;
         d.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         d.w_got = 1'b1;
         d.w_data = wdata[15:0];
         d.w_strb = wstrb[1:0];
      end
      if (q.aw_got && q.w_got) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = reset_combiner_pkg::RESP_OKAY;
         if (q.aw_addr[3:2] == reset_combiner_pkg::ADDR_STATUS[3:2]) begin
            // Writes only store values; no reset follows from them.
            if (q.w_strb[0]) begin
               d.status[7:0] = q.w_data[7:0];
            end
            if (q.w_strb[1]) begin
               d.status[15:8] = q.w_data[15:8];
            end
         end else if (q.aw_addr[3:2] != reset_combiner_pkg::ADDR_INFO[3:2]) begin
            d.bresp = reset_combiner_pkg::RESP_SLVERR;
         end
      end
      if (q.bvalid && bready) begin
         d.bvalid = 1'b0;
      end

      // The power-save instruction clears the timeout flag; a set wins.
      if (sleep_entry || idle_entry) begin
         d.status[reset_combiner_pkg::BIT_WDT_TIMEOUT] = 1'b0;
      end
      d.status = (d.status | set_vec) & reset_combiner_pkg::STATUS_IMPL_MASK;

      // Register reads.
      if (arvalid && arready) begin
         d.rvalid = 1'b1;
         d.rresp = reset_combiner_pkg::RESP_OKAY;
         if (araddr[3:2] == reset_combiner_pkg::ADDR_STATUS[3:2]) begin
            d.rdata = q.status;
         end else if (araddr[3:2] == reset_combiner_pkg::ADDR_INFO[3:2]) begin
            d.rdata = info_word;
         end else begin
            d.rdata = 16'h0000;
            d.rresp = reset_combiner_pkg::RESP_SLVERR;
         end
      end
      if (q.rvalid && rready) begin
         d.rvalid = 1'b0;
      end

      // Reset sequencer.
      unique case (q.state)
         reset_combiner_pkg::ST_RUN: begin
            if (src_any) begin
               d.state = reset_combiner_pkg::ST_HOLD;
               d.por_bor = q.bo_sync;
            end
         end
         reset_combiner_pkg::ST_HOLD: begin
            if (q.bo_sync) begin
               d.por_bor = 1'b1;
            end
            if (!src_any) begin
               d.state = reset_combiner_pkg::ST_DELAY;
               d.cnt = delay_load;
               if (clock_switch_enable && !q.por_bor) begin
                  d.clk_sel = current_osc_field;
               end else begin
                  d.clk_sel = new_osc_config_field;
               end
            end
         end
         reset_combiner_pkg::ST_DELAY: begin
            if (src_any) begin
               d.state = reset_combiner_pkg::ST_HOLD;
               d.por_bor = q.por_bor | q.bo_sync;
            end else if (q.cnt <= reset_combiner_pkg::CNT_W'(1)) begin
               d.state = reset_combiner_pkg::ST_RUN;
               d.por_pend = 1'b0;
               d.por_bor = 1'b0;
            end else begin
               d.cnt = q.cnt - reset_combiner_pkg::CNT_W'(1);
            end
         end
      endcase

      // Oscillator start-up timer restarts on each brown-out.
      if (q.bo_sync) begin
         d.ost_cnt = '0;
         d.ost_done = 1'b0;
      end else if (!q.ost_done) begin
         if (q.ost_cnt == reset_combiner_pkg::OST_LAST) begin
            d.ost_done = 1'b1;
         end else begin
            d.ost_cnt = q.ost_cnt + reset_combiner_pkg::OST_W'(1);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.status <= reset_combiner_pkg::STATUS_RST;
         q.state <= reset_combiner_pkg::ST_HOLD;
         q.por_pend <= 1'b1;
         q.por_bor <= 1'b1;
      end else if (clk_en) begin
         q <= d;
      end
   end

   // Checks.
   a_unimpl_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      q.rvalid |-> q.rdata[13:10] == 4'h0)
      else $error("Unimplemented status bits read nonzero.");

   a_trap_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      (trap_conflict && clk_en) |=> q.status[15])
      else $error("Trap conflict flag not set.");

   a_illegal_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      ((illegal_opcode || uninit_workreg_reset) && clk_en) |=> q.status[14])
      else $error("Illegal opcode flag not set.");

   a_mismatch_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      (config_word_mismatch && clk_en) |=> q.status[9] && system_reset_line)
      else $error("Mismatch flag or reset missing.");

   a_timeout_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      (watchdog_timeout && (sleep_entry || idle_entry) && clk_en) |=> q.status[4])
      else $error("Timeout flag lost to power-save clear.");

   a_source_reset: assert property (@(posedge aclk) disable iff (!aresetn)
      (src_any && clk_en) |=> system_reset_line)
      else $error("Active source did not assert reset.");

   a_release_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (q.state == reset_combiner_pkg::ST_HOLD && !src_any) |=> system_reset_line [*8])
      else $error("Reset released too early.");

   a_fuse_watchdog: assert property (@(posedge aclk) disable iff (!aresetn)
      fuse_watchdog_enable |-> watchdog_run)
      else $error("Watchdog stopped with fuse set.");

   a_fixed_clock_src: assert property (@(posedge aclk) disable iff (!aresetn)
      (q.state == reset_combiner_pkg::ST_HOLD && !src_any && !clock_switch_enable && clk_en)
      |=> clock_source_sel == $past(new_osc_config_field))
      else $error("Clock source not from configuration.");

   a_por_status: assert property (@(posedge aclk)
      $rose(aresetn) |-> q.status == reset_combiner_pkg::STATUS_RST && system_reset_line)
      else $error("Power-on status value wrong.");

   a_pin_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      (q.master_clear_pin_sync && clk_en) |=> q.status[7] && system_reset_line)
      else $error("Pin reset flag or reset missing.");

   a_brownout_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      (q.bo_sync && clk_en) |=> q.status[1] && system_reset_line)
      else $error("Brown-out flag or reset missing.");

   a_soft_reset_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      (reset_instruction && clk_en) |=> q.status[6] && system_reset_line)
      else $error("Reset instruction flag or reset missing.");

   a_sleep_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      (sleep_entry && clk_en) |=> q.status[3])
      else $error("Sleep flag not set.");

   a_idle_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      (idle_entry && clk_en) |=> q.status[2])
      else $error("Idle flag not set.");

   a_timeout_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      ((sleep_entry || idle_entry) && !watchdog_timeout && !(q.aw_got && q.w_got) && clk_en)
      |=> !q.status[4])
      else $error("Power-save did not clear timeout flag.");

   a_switch_clock_sel: assert property (@(posedge aclk) disable iff (!aresetn)
      (q.state == reset_combiner_pkg::ST_HOLD && !src_any && clock_switch_enable && !q.por_bor && clk_en)
      |=> clock_source_sel == $past(current_osc_field))
      else $error("Clock source not from current oscillator field.");

   a_por_clock_sel: assert property (@(posedge aclk) disable iff (!aresetn)
      (q.state == reset_combiner_pkg::ST_HOLD && !src_any && q.por_bor && clk_en)
      |=> clock_source_sel == $past(new_osc_config_field))
      else $error("Clock source after brown-out not from configuration.");

   a_unimpl_store_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      q.status[13:10] == 4'h0)
      else $error("Unimplemented status bits stored nonzero.");

   a_release_after_delay: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(system_reset_line) |-> $past(q.state) == reset_combiner_pkg::ST_DELAY)
      else $error("Reset released outside the delay count.");

   a_bor_long_delay: assert property (@(posedge aclk) disable iff (!aresetn)
      (q.bo_sync && clk_en) |=> q.por_bor)
      else $error("Brown-out did not request the start-up delay.");

   a_ost_restart: assert property (@(posedge aclk) disable iff (!aresetn)
      (q.bo_sync && clk_en) |=> !osc_clock_released)
      else $error("Oscillator clock not withheld on brown-out.");

   a_ost_full_count: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(q.ost_done) |-> $past(q.ost_cnt) == reset_combiner_pkg::OST_LAST)
      else $error("Oscillator released before full count.");

   c_pin_reset: cover property (@(posedge aclk) disable iff (!aresetn)
      $rose(q.master_clear_pin_sync) ##[1:600] $fell(system_reset_line));
   c_status_write: cover property (@(posedge aclk) disable iff (!aresetn)
      q.aw_got && q.w_got && q.aw_addr == reset_combiner_pkg::ADDR_STATUS);
   c_ost_done: cover property (@(posedge aclk) disable iff (!aresetn) $rose(q.ost_done));
   c_bor_release: cover property (@(posedge aclk) disable iff (!aresetn)
      $rose(q.bo_sync) ##[1:1000] $fell(system_reset_line));
   c_timeout_cleared: cover property (@(posedge aclk) disable iff (!aresetn) $fell(q.status[4]));

endmodule // reset_source_combiner

// ### dv/reset_source_model.sv
`timescale 1ns/1ps
// Drives one reset or power event on command; index 4 and 9 are pin levels.
module reset_source_model (
   // Clock and command.
   input wire logic aclk,
   input wire logic go,
   input wire logic [3:0] pick,
   // Source lines, one bit for each source.
   output logic [9:0] src
);
   logic [2:0] left = 3'h0;
   logic [3:0] cur = 4'h0;

   always @(posedge aclk) begin
      if (go) begin
         cur <= pick;
         // Pin levels stand long enough to pass the synchroniser.
         left <= (pick == 4'h4 || pick == 4'h9) ? 3'h4 : 3'h1;
      end else if (left != 3'h0) begin
         left <= left - 3'h1;
      end
   end

   assign src = (left != 3'h0) ? (10'h001 << cur) : 10'h000;
endmodule // reset_source_model

// ### dv/reset_source_combiner_tb.sv
`timescale 1ns/1ps
module reset_source_combiner_tb;
   localparam logic [2:0] OSC_NEW = 3'h5;
   localparam logic [2:0] OSC_CUR = 3'h2;
   typedef struct packed {
      logic [3:0] pick;
      logic [15:0] st;
      logic rst;
      logic [2:0] clk;
   } row_type;
   row_type rows [10] = '{
      '{4'h0, 16'h8000, 1'b1, OSC_CUR},
      '{4'h1, 16'h4000, 1'b1, OSC_CUR},
      '{4'h2, 16'h4000, 1'b1, OSC_CUR},
      '{4'h3, 16'h0200, 1'b1, OSC_CUR},
      '{4'h4, 16'h0080, 1'b1, OSC_CUR},
      '{4'h5, 16'h0040, 1'b1, OSC_CUR},
      '{4'h6, 16'h0010, 1'b1, OSC_CUR},
      '{4'h7, 16'h0008, 1'b0, OSC_CUR},
      '{4'h8, 16'h0004, 1'b0, OSC_CUR},
      '{4'h9, 16'h0002, 1'b1, OSC_NEW}
   };
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] awaddr = 4'h0;
   logic [3:0] araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic go = 1'b0, fuse = 1'b0, csw = 1'b1, reg_en = 1'b1;
   logic [3:0] pick = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic system_reset_line, regulator_sleep_keep, watchdog_run, osc_clock_released;
   logic [2:0] clock_source_sel;
   logic [9:0] src;
   int errors = 0;
   int n_compared = 0;

   always #20 aclk = ~aclk;

   reset_source_model u_reset_source_model (.aclk(aclk), .go(go), .pick(pick), .src(src));

   reset_source_combiner #(.POWER_UP_TIMER_CYCLES(21'd20)) u_reset_source_combiner (
      .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready),
      .master_clear_pin(src[4]), .brownout_reset(src[9]), .watchdog_timeout(src[6]),
      .reset_instruction(src[5]), .trap_conflict(src[0]), .illegal_opcode(src[1]),
      .uninit_workreg_reset(src[2]), .config_word_mismatch(src[3]), .sleep_entry(src[7]),
      .idle_entry(src[8]), .fuse_watchdog_enable(fuse), .clock_switch_enable(csw),
      .regulator_enabled(reg_en), .new_osc_config_field(OSC_NEW), .current_osc_field(OSC_CUR),
      .system_reset_line(system_reset_line), .regulator_sleep_keep(regulator_sleep_keep),
      .watchdog_run(watchdog_run), .clock_source_sel(clock_source_sel),
      .osc_clock_released(osc_clock_released)
   );

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask

   task automatic tally_and_finish;
      $display("compared=%0d errors=%0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'h3;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic wait_rel(output int n);
      n = 0;
      while (system_reset_line !== 1'b0 && n < 3000) begin
         @(posedge aclk);
         n++;
      end
      chk_bit(system_reset_line, 1'b0);
   endtask

   task automatic fire(input logic [3:0] p);
      go <= 1'b1;
      pick <= p;
      @(posedge aclk);
      go <= 1'b0;
      repeat (6) @(posedge aclk);
   endtask

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int n;
      int i;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(reset_combiner_pkg::ADDR_STATUS, d, r);
      chk_word(d, 32'h0003);
      chk_bit(system_reset_line, 1'b1);
      wait_rel(n);
      chk_bit(n >= 990 && n <= 1010, 1'b1);
      chk_bit(osc_clock_released, 1'b0);
      chk_word({29'h0, clock_source_sel}, {29'h0, OSC_NEW});
      repeat (30) @(posedge aclk);
      chk_bit(osc_clock_released, 1'b1);
      axi_wr(reset_combiner_pkg::ADDR_INFO, 32'hffff, r);
      chk_word({30'h0, r}, {30'h0, reset_combiner_pkg::RESP_OKAY});
      axi_rd(reset_combiner_pkg::ADDR_INFO, d, r);
      chk_word(d, 32'h000000b0);
      chk_word({30'h0, r}, {30'h0, reset_combiner_pkg::RESP_OKAY});
      for (i = 0; i < 10; i++) begin
         axi_wr(reset_combiner_pkg::ADDR_STATUS, 32'h0, r);
         fire(rows[i].pick);
         chk_bit(system_reset_line, rows[i].rst);
         wait_rel(n);
         axi_rd(reset_combiner_pkg::ADDR_STATUS, d, r);
         chk_word(d, {16'h0, rows[i].st});
         if (rows[i].rst) chk_word({29'h0, clock_source_sel}, {29'h0, rows[i].clk});
      end
      axi_wr(reset_combiner_pkg::ADDR_STATUS, 32'hffff, r);
      repeat (4) @(posedge aclk);
      chk_bit(system_reset_line, 1'b0);
      axi_rd(reset_combiner_pkg::ADDR_STATUS, d, r);
      chk_word(d, 32'hc3ff);
      chk_bit(regulator_sleep_keep, 1'b1);
      chk_bit(watchdog_run, 1'b1);
      axi_wr(reset_combiner_pkg::ADDR_STATUS, 32'h0010, r);
      chk_bit(regulator_sleep_keep, 1'b0);
      chk_bit(watchdog_run, 1'b0);
      fuse <= 1'b1;
      @(posedge aclk);
      @(posedge aclk);
      chk_bit(watchdog_run, 1'b1);
      fire(4'h7);
      axi_rd(reset_combiner_pkg::ADDR_STATUS, d, r);
      chk_word(d, 32'h0008);
      csw <= 1'b0;
      fire(4'h4);
      wait_rel(n);
      chk_word({29'h0, clock_source_sel}, {29'h0, OSC_NEW});
      reg_en <= 1'b0;
      fire(4'h9);
      wait_rel(n);
      chk_bit(n >= 515 && n <= 530, 1'b1);
      axi_wr(4'hc, 32'h1, r);
      chk_word({30'h0, r}, {30'h0, reset_combiner_pkg::RESP_SLVERR});
      axi_rd(4'hc, d, r);
      chk_word({30'h0, r}, {30'h0, reset_combiner_pkg::RESP_SLVERR});
      fire(4'h0);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      chk_bit(system_reset_line, 1'b1);
      aresetn <= 1'b1;
      axi_rd(reset_combiner_pkg::ADDR_STATUS, d, r);
      chk_word(d, 32'h0003);
      tally_and_finish();
   end

   initial begin
      repeat (40000) @(posedge aclk);
      errors++;
      tally_and_finish();
   end
endmodule // reset_source_combiner_tb
